// ### common/ipes_pkg.sv
// ingress port event statistics: sizes, register map, field layout, states
// assumes a single core clock; all offsets are byte addresses on a 32-bit APB
package ipes_pkg;
    localparam int unsigned NUM_PORTS = 6;
    localparam int unsigned PORT_W = 3;
    localparam int unsigned NUM_CNT = 4;
    localparam int unsigned CNT_IDX_W = 2;
    localparam int unsigned CNT_W = 40;
    localparam int unsigned LOW_W = 32;
    localparam int unsigned HIGH_W = 8;
    localparam int unsigned EV_W = 12;
    localparam int unsigned PRIO_W = 3;
    localparam int unsigned PRIO_N = 8;
    localparam int unsigned CLASS_W = 3;
    localparam int unsigned BYTES_W = 16;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ROW_W = NUM_CNT * CNT_W;

    // global page: paddr[11:8] == 0
    localparam logic [3:0] PAGE_GLOBAL = 4'h0;
    localparam logic [5:0] IDX_CLEAR = 6'h04;
    // port pages: 0x100 + port * 0x40; paddr[11:6] holds port + PORT_PAGE0
    localparam logic [5:0] PORT_PAGE0 = 6'h04;
    localparam logic [1:0] KIND_SETUP = 2'h0;
    localparam logic [1:0] KIND_LOW = 2'h1;
    localparam logic [1:0] KIND_HIGH = 2'h2;
    localparam logic [1:0] KIND_STICKY = 2'h3;

    // per_counter_setup fields and the clear register bit
    localparam int unsigned PRIO_LSB = 0;
    localparam int unsigned CLASS_LSB = 8;
    localparam int unsigned BYTE_SEL_BIT = 12;
    localparam int unsigned CLEAR_BIT = 0;

    localparam logic [PRIO_N-1:0] PRIO_RST = 8'h00;
    localparam logic [CLASS_W-1:0] CLASS_RST = 3'h0;
    localparam logic [EV_W-1:0] TRIG_RST = 12'h000;

    // frame class codes
    localparam logic [CLASS_W-1:0] CLS_OK_NOMATCH = 3'h0;
    localparam logic [CLASS_W-1:0] CLS_OK_MATCH = 3'h1;
    localparam logic [CLASS_W-1:0] CLS_ERR_MATCH = 3'h2;
    localparam logic [CLASS_W-1:0] CLS_ANY_MATCH = 3'h3;
    localparam logic [CLASS_W-1:0] CLS_ERR_NOMATCH = 3'h4;
    localparam logic [CLASS_W-1:0] CLS_ERR_ANY = 3'h5;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_BUS = 3'h1,
        ST_ACK = 3'h3,
        ST_CLR = 3'h2,
        ST_FRM = 3'h4
    } ipes_state_type;
endpackage

// ### hw/ipes_cnt_mem.sv
// counter storage: one row of four 40-bit counts per port
// assumes one read and one write per cycle; read data are registered
`timescale 1ns/1ns
module ipes_cnt_mem (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic rd_en_i,
    input wire logic [ipes_pkg::PORT_W-1:0] rd_addr_i,
    output logic [ipes_pkg::ROW_W-1:0] rd_data_o,
    input wire logic wr_en_i,
    input wire logic [ipes_pkg::PORT_W-1:0] wr_addr_i,
    input wire logic [ipes_pkg::ROW_W-1:0] wr_data_i
);
    import ipes_pkg::*;

    // array has no reset: contents are undefined until the clear sweep runs
    logic [ROW_W-1:0] mem_q [NUM_PORTS];
    logic [ROW_W-1:0] rd_data_q;

    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_q <= '0;
        end else if (rd_en_i) begin
            rd_data_q <= mem_q[rd_addr_i];
        end
    end

    assign rd_data_o = rd_data_q;
endmodule

// ### hw/ipes_top.sv
// ingress port statistics: four 40-bit counters per port, APB register slave
// assumes frames come from same-clock analyzer logic with a valid/ready handshake
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ns
module ipes_top (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ipes_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [ipes_pkg::DATA_W-1:0] pwdata_i,
    output logic pready_o,
    output logic [ipes_pkg::DATA_W-1:0] prdata_o,
    output logic pslverr_o,
    input wire logic frm_valid_i,
    output logic frm_ready_o,
    input wire logic [ipes_pkg::PORT_W-1:0] frm_port_i,
    input wire logic [ipes_pkg::PRIO_W-1:0] frm_prio_i,
    input wire logic [ipes_pkg::BYTES_W-1:0] frm_bytes_i,
    input wire logic frm_error_i,
    input wire logic frm_no_dest_i,
    input wire logic [3:0] frm_sticky_ev_i,
    input wire logic [3:0] frm_port_pol_ev_i,
    input wire logic [1:0] frm_storm_ev_i,
    input wire logic frm_acl_ev_i,
    input wire logic frm_loopback_i
);
    import ipes_pkg::*;

    function automatic logic class_hit(input logic [CLASS_W-1:0] code, input logic err,
                                       input logic match);
        logic hit;
        hit = 1'b0;
        unique case (code)
            CLS_OK_NOMATCH: hit = !err && !match;
            CLS_OK_MATCH: hit = !err && match;
            CLS_ERR_MATCH: hit = err && match;
            CLS_ANY_MATCH: hit = match;
            CLS_ERR_NOMATCH: hit = err && !match;
            CLS_ERR_ANY: hit = err;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    ipes_state_type state_q;
    ipes_state_type state_d;

    logic [EV_W-1:0] trig_q [NUM_CNT];
    logic [NUM_PORTS-1:0][NUM_CNT-1:0][PRIO_N-1:0] prio_mask_q;
    logic [NUM_PORTS-1:0][NUM_CNT-1:0][CLASS_W-1:0] class_q;
    logic [NUM_PORTS-1:0][NUM_CNT-1:0] byte_sel_q;
    logic [NUM_PORTS-1:0][EV_W-1:0] sticky_q;
    logic [HIGH_W-1:0] shadow_q;
    logic clr_busy_q;
    logic [PORT_W-1:0] clr_idx_q;

    logic [PORT_W-1:0] f_port_q;
    logic [PRIO_W-1:0] f_prio_q;
    logic [BYTES_W-1:0] f_bytes_q;
    logic f_err_q;
    logic [EV_W-1:0] f_ev_q;

    logic ack_q;
    logic err_q;
    logic [DATA_W-1:0] prdata_q;

    // frame side
    logic [EV_W-1:0] ev_vec;
    logic frm_take;
    logic frm_port_ok;
    assign ev_vec = {frm_loopback_i, frm_acl_ev_i, frm_storm_ev_i,
                     frm_port_pol_ev_i,
                     frm_sticky_ev_i};

    // apb decode
    logic access;
    logic aligned;
    logic glb_page;
    logic trig_hit;
    logic clr_hit;
    logic [5:0] port_page;
    logic port_hit;
    logic [PORT_W-1:0] a_port;
    logic [1:0] a_kind;
    logic [CNT_IDX_W-1:0] a_cnt;
    logic cfg_hit;
    logic lo_hit;
    logic hi_hit;
    logic sticky_hit;
    logic cnt_hit;
    logic mapped;
    logic bus_wait;
    logic ack_set;
    logic bus_done;
    logic bus_wr;

    assign access = psel_i && penable_i;
    assign aligned = paddr_i[1:0] == 2'h0;
    assign glb_page = paddr_i[11:8] == PAGE_GLOBAL;
    assign trig_hit = aligned && glb_page && paddr_i[7:4] == 4'h0;
    assign clr_hit = aligned && glb_page && paddr_i[7:2] == IDX_CLEAR;
    assign port_page = paddr_i[11:6];
    assign port_hit = aligned && port_page >= PORT_PAGE0 &&
                      port_page < PORT_PAGE0 + 6'(NUM_PORTS);
    assign a_port = PORT_W'(port_page - PORT_PAGE0);
    assign a_kind = paddr_i[5:4];
    assign a_cnt = paddr_i[3:2];
    assign cfg_hit = port_hit && a_kind == KIND_SETUP;
    assign lo_hit = port_hit && a_kind == KIND_LOW;
    assign hi_hit = port_hit && a_kind == KIND_HIGH;
    assign sticky_hit = port_hit && a_kind == KIND_STICKY && a_cnt == 2'h0;
    assign cnt_hit = lo_hit || hi_hit;
    assign mapped = trig_hit || clr_hit || cfg_hit || sticky_hit || cnt_hit;

    // a pending counter access wins over frames so software is never starved
    assign bus_wait = access && cnt_hit && !ack_q;
    assign ack_set = access && !ack_q && (!cnt_hit || state_q == ST_BUS);
    assign bus_done = access && ack_q;
    assign bus_wr = bus_done && pwrite_i;

    assign frm_ready_o = state_q == ST_IDLE && !clr_busy_q && !bus_wait;
    assign frm_take = frm_valid_i && frm_ready_o;
    assign frm_port_ok = frm_port_i < PORT_W'(NUM_PORTS);

    // counter row from memory
    logic [ROW_W-1:0] row_rd;
    logic [NUM_CNT-1:0][CNT_W-1:0] cur_cnt;
    logic [NUM_CNT-1:0][CNT_W-1:0] frm_cnt;
    logic [NUM_CNT-1:0][CNT_W-1:0] bus_cnt;
    logic [CNT_W-1:0] sel_cnt;
    assign cur_cnt = row_rd;
    assign sel_cnt = cur_cnt[a_cnt];

    // per-counter evaluation for the captured frame, using its ingress port
    genvar c;
    generate
        for (c = 0; c < NUM_CNT; c++) begin : g_cnt
            logic prio_ok;
            logic ev_match;
            logic hit;
            logic [CNT_W-1:0] step;
            assign prio_ok = prio_mask_q[f_port_q][c][f_prio_q];
            assign ev_match = |(trig_q[c] & f_ev_q);
            assign hit = prio_ok &&
                         class_hit(class_q[f_port_q][c], f_err_q, ev_match);
            assign step = byte_sel_q[f_port_q][c] ? CNT_W'(f_bytes_q) : CNT_W'(1);
            // 40-bit add drops the carry: silent wrap
            assign frm_cnt[c] = hit ? cur_cnt[c] + step : cur_cnt[c];
            assign bus_cnt[c] = (a_cnt != CNT_IDX_W'(c)) ? cur_cnt[c] :
                                lo_hit ? {cur_cnt[c][CNT_W-1:LOW_W], pwdata_i} :
                                {pwdata_i[HIGH_W-1:0], cur_cnt[c][LOW_W-1:0]};
        end
    endgenerate

    // memory port steering
    logic go_bus;
    logic go_frm;
    logic rd_en;
    logic [PORT_W-1:0] rd_addr;
    logic wr_en;
    logic [PORT_W-1:0] wr_addr;
    logic [ROW_W-1:0] wr_data;
    assign go_bus = state_q == ST_IDLE && !clr_busy_q && bus_wait;
    assign go_frm = frm_take && frm_port_ok;
    assign rd_en = go_bus || go_frm;
    assign rd_addr = go_bus ? a_port : frm_port_i;
    assign wr_en = state_q == ST_FRM || state_q == ST_CLR ||
                   (state_q == ST_ACK && bus_wr);
    assign wr_addr = state_q == ST_FRM ? f_port_q :
                     state_q == ST_CLR ? clr_idx_q : a_port;
    assign wr_data = state_q == ST_FRM ? frm_cnt :
                     state_q == ST_CLR ? ROW_W'(0) : bus_cnt;

    ipes_cnt_mem u_mem (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .rd_en_i(rd_en),
        .rd_addr_i(rd_addr),
        .rd_data_o(row_rd),
        .wr_en_i(wr_en),
        .wr_addr_i(wr_addr),
        .wr_data_i(wr_data)
    );

    // read data selection
    logic [DATA_W-1:0] cfg_word;
    logic [DATA_W-1:0] rd_mux;
    assign cfg_word = DATA_W'({byte_sel_q[a_port][a_cnt], 1'b0,
                               class_q[a_port][a_cnt], prio_mask_q[a_port][a_cnt]});
    assign rd_mux = !mapped ? DATA_W'(0) :
                    trig_hit ? DATA_W'(trig_q[paddr_i[3:2]]) :
                    clr_hit ? DATA_W'(clr_busy_q) :
                    cfg_hit ? cfg_word :
                    sticky_hit ? DATA_W'(sticky_q[a_port]) :
                    lo_hit ? sel_cnt[LOW_W-1:0] :
                    DATA_W'(shadow_q);

    // sequencer
    logic clr_last;
    assign clr_last = clr_idx_q == PORT_W'(NUM_PORTS - 1);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (clr_busy_q) begin
                    state_d = ST_CLR;
                end else if (go_bus) begin
                    state_d = ST_BUS;
                end else if (go_frm) begin
                    state_d = ST_FRM;
                end
            end
            ST_BUS: state_d = ST_ACK;
            ST_ACK: state_d = ST_IDLE;
            ST_FRM: state_d = ST_IDLE;
            ST_CLR: begin
                if (clr_last) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // frame capture; the mac has already dropped runts, pause and control frames
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            f_port_q <= '0;
            f_prio_q <= '0;
            f_bytes_q <= '0;
            f_err_q <= 1'b0;
            f_ev_q <= '0;
        end else if (go_frm) begin
            f_port_q <= frm_port_i;
            f_prio_q <= frm_prio_i;
            f_bytes_q <= frm_bytes_i;
            f_err_q <= frm_error_i || frm_no_dest_i;
            f_ev_q <= ev_vec;
        end
    end

    // clear sweep: one memory row per cycle, frames held off meanwhile
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            clr_busy_q <= 1'b0;
            clr_idx_q <= '0;
        end else begin
            if (state_q == ST_CLR) begin
                clr_idx_q <= clr_last ? PORT_W'(0) : clr_idx_q + PORT_W'(1);
                if (clr_last) begin
                    clr_busy_q <= 1'b0;
                end
            end
            if (bus_wr && clr_hit && pwdata_i[CLEAR_BIT]) begin
                clr_busy_q <= 1'b1;
            end
        end
    end

    // sticky events: set by frames, zeroed only by the sweep
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sticky_q <= '0;
        end else if (state_q == ST_CLR) begin
            sticky_q[clr_idx_q] <= '0;
        end else if (state_q == ST_FRM) begin
            sticky_q[f_port_q] <= sticky_q[f_port_q] | f_ev_q;
        end
    end

    // shadow of the high byte, taken when a low-word read completes
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shadow_q <= '0;
        end else if (state_q == ST_CLR) begin
            shadow_q <= '0;
        end else if (bus_done && !pwrite_i && lo_hit) begin
            shadow_q <= sel_cnt[CNT_W-1:LOW_W];
        end
    end

    // configuration registers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                trig_q[i] <= TRIG_RST;
            end
        end else if (bus_wr && trig_hit) begin
            trig_q[paddr_i[3:2]] <= pwdata_i[EV_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prio_mask_q <= {(NUM_PORTS * NUM_CNT){PRIO_RST}};
            class_q <= {(NUM_PORTS * NUM_CNT){CLASS_RST}};
            byte_sel_q <= '0;
        end else if (bus_wr && cfg_hit) begin
            prio_mask_q[a_port][a_cnt] <= pwdata_i[PRIO_LSB +: PRIO_N];
            class_q[a_port][a_cnt] <= pwdata_i[CLASS_LSB +: CLASS_W];
            byte_sel_q[a_port][a_cnt] <= pwdata_i[BYTE_SEL_BIT];
        end
    end

    // apb answer: pready one cycle after data are ready, read data registered
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            prdata_q <= '0;
        end else if (ack_set) begin
            ack_q <= 1'b1;
            err_q <= !mapped;
            prdata_q <= pwrite_i ? DATA_W'(0) : rd_mux;
        end else begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end
    end

    assign pready_o = ack_q;
    assign pslverr_o = ack_q && err_q;
    assign prdata_o = prdata_q;
endmodule

// ### tb/ipes_top_asserts.sv
// checker: apb answer timing, error replies and frame pacing at the ipes_top ports
// assumes it is bound to ipes_top and sees only that module's ports
`timescale 1ns/1ns
module ipes_top_asserts (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic [31:0] prdata_o,
    input wire logic pslverr_o,
    input wire logic frm_valid_i,
    input wire logic frm_ready_o,
    input wire logic [2:0] frm_port_i
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    wire acc = psel_i && penable_i;
    wire take = frm_valid_i && frm_ready_o;
    ack_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready held longer than one cycle");
    access_wait_a: assert property (psel_i && $rose(penable_i) |-> !pready_o)
        else $error("ready in first access cycle");
    ack_bound_a: assert property (acc && !pready_o |-> ##[1:16] pready_o)
        else $error("access never answered");
    ack_in_access_a: assert property (pready_o |-> acc)
        else $error("ready outside an access phase");
    err_with_ack_a: assert property (pslverr_o |-> pready_o)
        else $error("error reply without ready");
    misalign_err_a: assert property (pready_o && paddr_i[1:0] != 2'h0 |-> pslverr_o)
        else $error("misaligned access not refused");
    unmapped_zero_a: assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
        else $error("refused read returned data");
    // frames for ports 6 and 7 are dropped without an update cycle, so ready stays up
    take_gap_a: assert property (take && frm_port_i < 3'h6 |=> !frm_ready_o)
        else $error("frame taken on back to back cycles");
    clear_stall_a: assert property (pready_o && pwrite_i && paddr_i == 12'h010 && pwdata_i[0]
        |=> !frm_ready_o)
        else $error("frames accepted while clearing");
    c_clear: cover property (pready_o && pwrite_i && paddr_i == 12'h010);
    c_err: cover property (pready_o && pslverr_o);
    c_take: cover property (take);
endmodule

// ### tb/ipes_frame_src.sv
// upstream analyzer model: offers one frame at a time on the valid/ready handshake
// assumes the bench calls send() and waits for it to return before the next frame
`timescale 1ns/1ns
module ipes_frame_src (
    input wire logic sys_clk_i,
    input wire logic frm_ready_i,
    output logic frm_valid_o,
    output logic [2:0] port_o,
    output logic [2:0] prio_o,
    output logic [15:0] bytes_o,
    output logic error_o,
    output logic no_dest_o,
    output logic [11:0] ev_o
);
    initial begin
        frm_valid_o = 1'b0;
        {port_o, prio_o, bytes_o, error_o, no_dest_o, ev_o} = '0;
    end
    task automatic send(input logic [2:0] p, input logic [2:0] pr, input logic [15:0] b,
                        input logic er, input logic nd, input logic [11:0] ev);
        @(posedge sys_clk_i);
        frm_valid_o <= 1'b1;
        {port_o, prio_o, bytes_o, error_o, no_dest_o, ev_o} <= {p, pr, b, er, nd, ev};
        // the frame stands until the rising edge at which ready is sampled high
        @(posedge sys_clk_i);
        while (frm_ready_i !== 1'b1) @(posedge sys_clk_i);
        frm_valid_o <= 1'b0;
        // released fields show garbage, never the last frame
        {port_o, prio_o, bytes_o, error_o, no_dest_o, ev_o} <= ~{p, pr, b, er, nd, ev};
    endtask
endmodule

// ### tb/ipes_top_tb.sv
// self-checking bench for ipes_top: apb register tasks plus an upstream frame model
// assumes a 20 MHz core clock and a counter clear before counts are trusted
`timescale 1ns/1ns
module ipes_top_tb;
    import ipes_pkg::*;
    logic clk, rst, psel, pen, pwr, pready, perr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic fv, fr, fe, fnd;
    logic [2:0] fp, fpr;
    logic [15:0] fb;
    logic [11:0] fev;
    int compares, miscompares, i, k, exp;
    int cls_n[8] = '{1, 1, 1, 2, 1, 2, 0, 0};

    ipes_top u_ipes_top (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
        .prdata_o(prdata), .pslverr_o(perr), .frm_valid_i(fv), .frm_ready_o(fr),
        .frm_port_i(fp), .frm_prio_i(fpr), .frm_bytes_i(fb), .frm_error_i(fe),
        .frm_no_dest_i(fnd),
        .frm_sticky_ev_i(fev[3:0]),
        .frm_port_pol_ev_i(fev[7:4]),
        .frm_storm_ev_i(fev[9:8]), .frm_acl_ev_i(fev[10]), .frm_loopback_i(fev[11]));
    ipes_frame_src u_ipes_frame_src (.sys_clk_i(clk), .frm_ready_i(fr), .frm_valid_o(fv),
        .port_o(fp), .prio_o(fpr), .bytes_o(fb), .error_o(fe), .no_dest_o(fnd), .ev_o(fev));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [11:0] pa(input int p, input int off);
        return 12'(256 + 64 * p + off);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            miscompares++;
            $display("mismatch at %0t: got %h exp %h", $time, got, want);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // ready and read data are taken at one rising edge, and only then released
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] want);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, want);
    endtask
    task automatic rde(input logic [11:0] a);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
    endtask
    task automatic clear_all();
        logic [31:0] q;
        logic e;
        int n;
        wr(12'h010, 32'h1);
        n = 0;
        do begin
            apb(1'b0, 12'h010, 32'h0, q, e);
            n++;
        end while (q[0] !== 1'b0 && n < 50);
        chk({31'h0, q[0]}, 32'h0);
    endtask
    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        miscompares++;
        test_done();
    end

    initial begin
        rst = 1'b1;
        {psel, pen, pwr, paddr, pwdata} = '0;
        compares = 0;
        miscompares = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 4; i++) rd(12'(4 * i), 32'h0);
        for (i = 0; i < 4; i++) rd(pa(0, 4 * i), 32'h0);
        rde(12'h0fc);
        rde(12'h102);
        wr(12'h00c, 32'hffffffff);
        rd(12'h00c, 32'h00000fff);
        $display("test register map done");
        clear_all();
        for (i = 0; i < 4; i++) begin
            rd(pa(1, 16 + 4 * i), 32'h0);
            rd(pa(1, 32 + 4 * i), 32'h0);
        end
        // every frame class code against one fixed set of four frames
        wr(12'h000, 32'h010);
        exp = 0;
        for (k = 0; k < 8; k++) begin
            wr(pa(2, 0), 32'h0ff + 32'(k) * 256);
            u_ipes_frame_src.send(3'h2, 3'h0, 16'd64, 1'b0, 1'b0, 12'h000);
            u_ipes_frame_src.send(3'h2, 3'h1, 16'd64, 1'b0, 1'b0, 12'h010);
            u_ipes_frame_src.send(3'h2, 3'h2, 16'd64, 1'b1, 1'b0, 12'h000);
            u_ipes_frame_src.send(3'h2, 3'h3, 16'd64, 1'b0, 1'b1, 12'h010);
            exp += cls_n[k];
            rd(pa(2, 16), 32'(exp));
        end
        $display("test frame classes done");
        wr(12'h004, 32'h800);
        wr(pa(2, 4), 32'h1120);
        u_ipes_frame_src.send(3'h2, 3'h5, 16'd100, 1'b0, 1'b0, 12'h800);
        u_ipes_frame_src.send(3'h2, 3'h4, 16'd100, 1'b0, 1'b0, 12'h800);
        u_ipes_frame_src.send(3'h2, 3'h5, 16'd100, 1'b0, 1'b0, 12'h4f0);
        u_ipes_frame_src.send(3'h2, 3'h5, 16'd7, 1'b0, 1'b0, 12'h80f);
        rd(pa(2, 20), 32'd107);
        wr(pa(2, 48), 32'h0);
        rd(pa(2, 48), 32'hcff);
        $display("test filters and sticky done");
        wr(pa(3, 12), 32'h10ff);
        wr(pa(3, 28), 32'hfffffffe);
        wr(pa(3, 44), 32'h12);
        rd(pa(3, 28), 32'hfffffffe);
        u_ipes_frame_src.send(3'h3, 3'h0, 16'd5, 1'b0, 1'b0, 12'h000);
        rd(pa(3, 44), 32'h12);
        rd(pa(3, 28), 32'h3);
        rd(pa(3, 44), 32'h13);
        wr(pa(3, 28), 32'hffffffff);
        wr(pa(3, 44), 32'hff);
        u_ipes_frame_src.send(3'h3, 3'h7, 16'd1, 1'b0, 1'b0, 12'h000);
        u_ipes_frame_src.send(3'h4, 3'h0, 16'd9, 1'b0, 1'b0, 12'h000);
        u_ipes_frame_src.send(3'h6, 3'h0, 16'd9, 1'b0, 1'b0, 12'h000);
        rd(pa(3, 28), 32'h0);
        rd(pa(3, 44), 32'h0);
        rd(pa(4, 16), 32'h0);
        $display("test shadow and wrap done");
        clear_all();
        rd(pa(2, 16), 32'h0);
        rd(pa(2, 48), 32'h0);
        $display("test final clear done");
        test_done();
    end
endmodule

bind ipes_top ipes_top_asserts u_ipes_top_asserts (.sys_clk_i, .rst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .frm_valid_i,
    .frm_ready_o, .frm_port_i);
